//--- logic/smr_consts.vh
// constants for the fifth mode register: field positions, codes, reset values
// assumes inclusion by the parity pipe and controller design files of the mode register block
`ifndef SMR_CONSTS_VH
`define SMR_CONSTS_VH

// register image
`define SMR_W           22
`define SMR_RESET       22'h000000

// field positions
`define SMR_RSV_TOP     21
`define SMR_SEL_HI      20
`define SMR_SEL_LO      18
`define SMR_RSV_A17     17
`define SMR_RSV_A13     13
`define SMR_RD_INV      12
`define SMR_WR_INV      11
`define SMR_WR_MASK     10
`define SMR_PERSIST     9
`define SMR_PARK_HI     8
`define SMR_PARK_LO     6
`define SMR_BUF_OFF     5
`define SMR_PAR_ERR     4
`define SMR_CRC_ERR     3
`define SMR_LAT_HI      2
`define SMR_LAT_LO      0

// register select codes
`define SMR_SEL_SELF    3'h5
`define SMR_SEL_NEVER   3'h7

// parity latency codes and their clock counts
`define SMR_LAT_OFF     3'h0
`define SMR_LAT_C4      3'h1
`define SMR_LAT_C5      3'h2
`define SMR_LAT_C6      3'h3
`define SMR_LAT_C8      3'h4
`define SMR_CLK_C4      4'h4
`define SMR_CLK_C5      4'h5
`define SMR_CLK_C6      4'h6
`define SMR_CLK_C8      4'h8
`define SMR_CLK_NONE    4'h0

// delay line depth, the longest parity latency
`define SMR_PIPE_DEPTH  8

// parked termination divisors of the reference resistor
`define SMR_DIV_OFF     3'h0
`define SMR_DIV_1       3'h1
`define SMR_DIV_2       3'h2
`define SMR_DIV_3       3'h3
`define SMR_DIV_4       3'h4
`define SMR_DIV_5       3'h5
`define SMR_DIV_6       3'h6
`define SMR_DIV_7       3'h7

`endif

//--- logic/smr_pin_filter.v
// three-stage input filter for a pin from outside the clock domain
// assumes one clock; output moves only once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module smr_pin_filter #(
  parameter W   = 1
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] pin,
  output reg  [W-1:0] level
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  integer     i;

  always @(posedge clk) begin
    if (rst) begin
      s1_q  <= {W{1'b0}};
      s2_q  <= {W{1'b0}};
      s3_q  <= {W{1'b0}};
      level <= {W{1'b0}};
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_q[i] == s3_q[i]) begin
          level[i] <= s3_q[i];
        end
      end
    end
  end
endmodule // smr_pin_filter
`default_nettype wire

//--- logic/smr_parity_pipe.v
// delay line that holds each registered command until its parity latency expires
// assumes the latency in clocks is 0 (bypass) or 1 to the line depth
`timescale 1ns/10ps
`default_nettype none
`include "smr_consts.vh"
module smr_parity_pipe (
  input  wire              clk,
  input  wire              rst,
  input  wire [3:0]        lat,
  input  wire              in_valid,
  input  wire              in_ok,
  input  wire              in_mrs,
  input  wire [`SMR_W-1:0] in_data,
  output reg               out_valid,
  output reg               out_ok,
  output reg               out_mrs,
  output reg  [`SMR_W-1:0] out_data
);
  localparam EW = `SMR_W + 3;
  reg [EW-1:0] line_q [0:`SMR_PIPE_DEPTH-1];
  reg [EW-1:0] tap;
  integer      i;

  always @(posedge clk) begin
    if (rst) begin
      for (i = 0; i < `SMR_PIPE_DEPTH; i = i + 1) begin
        line_q[i] <= {EW{1'b0}};
      end
    end else begin
      line_q[0] <= {in_valid, in_ok, in_mrs, in_data};
      for (i = 1; i < `SMR_PIPE_DEPTH; i = i + 1) begin
        line_q[i] <= line_q[i-1];
      end
    end
  end

  // a latency change while commands are in flight may drop or repeat them;
  // software is expected to reprogram only when the bus is idle
  always @* begin
    tap = {EW{1'b0}};
    if (lat == `SMR_CLK_NONE) begin
      tap = {in_valid, in_ok, in_mrs, in_data};
    end else begin
      tap = line_q[lat[2:0] - 3'h1];
      if (lat[3]) begin
        tap = line_q[`SMR_PIPE_DEPTH-1];
      end
    end
    out_valid = tap[EW-1];
    out_ok    = tap[EW-2];
    out_mrs   = tap[EW-3];
    out_data  = tap[`SMR_W-1:0];
  end
endmodule // smr_parity_pipe
`default_nettype wire

//--- logic/smr_ctrl.v
// fifth mode register of the memory device: decode, storage and side effects
// assumes command pins are launched on CORE_CLK; the termination pin is filtered
// How it works
// - a mode-set command loads this register from bank-group, bank and address pins
// - BG to bits 21:20, BA to 19:18, A17 to 17, A13..A0 to 13..0
// - bits 20:18 pick the target register; code 111 is never used
// - bit 12 enables read inversion, bit 11 write inversion
// - bit 10 enables write masking, which touches writes only
// - bit 9 selects persistent parity error mode
// - bits 8:6 select parked termination divisor 4,2,6,1,5,3,7 or off
// - bit 5 set disables the termination input buffer in power-down
// - buffer off means floating input tolerated and nominal termination withheld
// - a detected parity error sets flag bit 4
// - a detected write CRC error sets flag bit 3
// - both flags stick until a mode-set to this register clears them
// - bits 2:0 give parity latency off, 4, 5, 6 or 8 clocks
// - non-persistent mode stops parity checking while the parity flag is set
// - parity off by default; when on, commands run only after passing
// - parity covers activate, strobes, address, bank and bank-group pins
// - inversion and masking exist only on wide organisations
// - readout ignores read inversion and returns plain data
`timescale 1ns/10ps
`default_nettype none
`include "smr_consts.vh"
module smr_ctrl (
  input  wire              CORE_CLK,
  input  wire              RST,
  input  wire              CKE,
  input  wire              CS_N,
  input  wire              ACT_N,
  input  wire              RAS_N,
  input  wire              CAS_N,
  input  wire              WE_N,
  input  wire [1:0]        BG,
  input  wire [1:0]        BA,
  input  wire              ADDR_A17,
  input  wire [13:0]       ADDR,
  input  wire              CMD_PARITY_PIN,
  input  wire              DIE_TERM_CTL,
  input  wire              POWER_DOWN,
  input  wire              MULTIPURPOSE_READOUT,
  input  wire              ORG_WIDE,
  input  wire              CRC_ERR_DETECT,
  output reg  [`SMR_W-1:0] MODE_REG_FIVE,
  output reg               RD_INV_EN,
  output reg               WR_INV_EN,
  output reg               WR_MASK_EN,
  output reg               PERSIST_MODE,
  output reg  [2:0]        PARKED_TERM_DIV,
  output reg               TERM_BUF_ON,
  output reg               NOM_TERM_EN,
  output reg               PARITY_ERR_FLAG,
  output reg               CRC_ERR_FLAG,
  output reg  [3:0]        PARITY_LAT_CLKS,
  output reg               PARITY_CHECK_ON,
  output reg               PARITY_ERR_PULSE,
  output reg               CMD_EXEC,
  output reg               CMD_DROP,
  output reg               CFG_SUSPECT
);
  // registered command pins, same clock as the controller launches them
  reg                cke_q;
  reg                cs_n_q;
  reg                act_n_q;
  reg                ras_n_q;
  reg                cas_n_q;
  reg                we_n_q;
  reg  [1:0]         bg_q;
  reg  [1:0]         ba_q;
  reg                a17_q;
  reg  [13:0]        addr_q;
  reg                par_q;

  // stored configuration and sticky flags
  reg  [`SMR_W-1:0]  cfg_q;
  reg  [`SMR_W-1:0]  cfg_d;
  reg                par_err_q;
  reg                par_err_d;
  reg                crc_err_q;
  reg                crc_err_d;

  // organisation strap, caught once after reset release
  reg                strap_done_q;
  reg                org_wide_q;

  wire               cmd_sel;
  wire               cmd_mrs;
  wire [`SMR_W-1:0]  pin_image;
  wire               parity_bad;
  wire               check_on;
  wire               cmd_ok;
  wire               par_err_set;
  wire               term_level;
  wire               exec_valid;
  wire               exec_ok;
  wire               exec_mrs;
  wire [`SMR_W-1:0]  exec_data;
  wire               load;
  wire               buf_off_pd;
  reg  [3:0]         lat_clks;
  reg  [2:0]         park_div;
  reg  [3:0]         lat_next;
  wire               check_on_d;
  wire               lat_flush;

  always @(posedge CORE_CLK) begin
    if (RST) begin
      cke_q   <= 1'b0;
      cs_n_q  <= 1'b1;
      act_n_q <= 1'b1;
      ras_n_q <= 1'b1;
      cas_n_q <= 1'b1;
      we_n_q  <= 1'b1;
      bg_q    <= 2'h0;
      ba_q    <= 2'h0;
      a17_q   <= 1'b0;
      addr_q  <= 14'h0000;
      par_q   <= 1'b0;
    end else begin
      cke_q   <= CKE;
      cs_n_q  <= CS_N;
      act_n_q <= ACT_N;
      ras_n_q <= RAS_N;
      cas_n_q <= CAS_N;
      we_n_q  <= WE_N;
      bg_q    <= BG;
      ba_q    <= BA;
      a17_q   <= ADDR_A17;
      addr_q  <= ADDR;
      par_q   <= CMD_PARITY_PIN;
    end
  end

  assign cmd_sel = cke_q & ~cs_n_q;
  // a mode-set is decoded only with activate high and all three strobes low
  assign cmd_mrs = cmd_sel & act_n_q & ~ras_n_q & ~cas_n_q & ~we_n_q;

  // strobe pins carry no register bits, so 16:14 stay zero
  assign pin_image = {bg_q, ba_q, a17_q, 3'h0, addr_q};

  // even parity over everything but clock enable, termination and select
  assign parity_bad = ^{act_n_q, ras_n_q, cas_n_q, we_n_q, bg_q, ba_q, a17_q, addr_q, par_q};

  // latency code to clocks; reserved codes leave checking off
  always @* begin
    lat_clks = `SMR_CLK_NONE;
    case (cfg_q[`SMR_LAT_HI:`SMR_LAT_LO])
      `SMR_LAT_C4: lat_clks = `SMR_CLK_C4;
      `SMR_LAT_C5: lat_clks = `SMR_CLK_C5;
      `SMR_LAT_C6: lat_clks = `SMR_CLK_C6;
      `SMR_LAT_C8: lat_clks = `SMR_CLK_C8;
      default:     lat_clks = `SMR_CLK_NONE;
    endcase
  end

  // same decode of the value being written, so the outputs move with the image
  always @* begin
    lat_next = `SMR_CLK_NONE;
    case (cfg_d[`SMR_LAT_HI:`SMR_LAT_LO])
      `SMR_LAT_C4: lat_next = `SMR_CLK_C4;
      `SMR_LAT_C5: lat_next = `SMR_CLK_C5;
      `SMR_LAT_C6: lat_next = `SMR_CLK_C6;
      `SMR_LAT_C8: lat_next = `SMR_CLK_C8;
      default:     lat_next = `SMR_CLK_NONE;
    endcase
  end

  // non-persistent mode goes quiet after the first error
  assign check_on = (lat_clks != `SMR_CLK_NONE) &
                    (cfg_q[`SMR_PERSIST] | ~par_err_q);
  assign cmd_ok      = ~check_on | ~parity_bad;
  assign par_err_set = cmd_sel & check_on & parity_bad;
  assign check_on_d  = (lat_next != `SMR_CLK_NONE) & (cfg_d[`SMR_PERSIST] | ~par_err_d);
  // a latency change empties the line, else the loading command would be tapped again
  assign lat_flush   = (lat_next != lat_clks);

  smr_parity_pipe u_pipe (
    .clk       (CORE_CLK),
    .rst       (RST | lat_flush),
    .lat       (lat_clks),
    .in_valid  (cmd_sel),
    .in_ok     (cmd_ok),
    .in_mrs    (cmd_mrs),
    .in_data   (pin_image),
    .out_valid (exec_valid),
    .out_ok    (exec_ok),
    .out_mrs   (exec_mrs),
    .out_data  (exec_data)
  );

  // other select values belong to sibling registers; 111 is simply not ours
  assign load = exec_valid & exec_ok & exec_mrs &
                (exec_data[`SMR_SEL_HI:`SMR_SEL_LO] == `SMR_SEL_SELF);

  always @* begin
    cfg_d = cfg_q;
    if (load) begin
      cfg_d = exec_data;
      // flag positions are status, not configuration
      cfg_d[`SMR_PAR_ERR] = 1'b0;
      cfg_d[`SMR_CRC_ERR] = 1'b0;
    end
  end

  // a set in the same cycle as the clearing mode-set wins
  always @* begin
    par_err_d = par_err_set | (par_err_q & ~load);
    crc_err_d = CRC_ERR_DETECT | (crc_err_q & ~load);
  end

  always @(posedge CORE_CLK) begin
    if (RST) begin
      cfg_q     <= `SMR_RESET;
      par_err_q <= 1'b0;
      crc_err_q <= 1'b0;
    end else begin
      cfg_q     <= cfg_d;
      par_err_q <= par_err_d;
      crc_err_q <= crc_err_d;
    end
  end

  always @(posedge CORE_CLK) begin
    if (RST) begin
      strap_done_q <= 1'b0;
      org_wide_q   <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      org_wide_q   <= ORG_WIDE;
    end
  end

  smr_pin_filter #(
    .W (1)
  ) u_term_filter (
    .clk   (CORE_CLK),
    .rst   (RST),
    .pin   (DIE_TERM_CTL),
    .level (term_level)
  );

  // code order is not monotonic in resistance, hence a table
  always @* begin
    park_div = `SMR_DIV_OFF;
    case (cfg_d[`SMR_PARK_HI:`SMR_PARK_LO])
      3'h1:    park_div = `SMR_DIV_4;
      3'h2:    park_div = `SMR_DIV_2;
      3'h3:    park_div = `SMR_DIV_6;
      3'h4:    park_div = `SMR_DIV_1;
      3'h5:    park_div = `SMR_DIV_5;
      3'h6:    park_div = `SMR_DIV_3;
      3'h7:    park_div = `SMR_DIV_7;
      default: park_div = `SMR_DIV_OFF;
    endcase
  end

  assign buf_off_pd = POWER_DOWN & cfg_d[`SMR_BUF_OFF];

  always @(posedge CORE_CLK) begin
    if (RST) begin
      MODE_REG_FIVE    <= `SMR_RESET;
      RD_INV_EN        <= 1'b0;
      WR_INV_EN        <= 1'b0;
      WR_MASK_EN       <= 1'b0;
      PERSIST_MODE     <= 1'b0;
      PARKED_TERM_DIV  <= `SMR_DIV_OFF;
      TERM_BUF_ON      <= 1'b1;
      NOM_TERM_EN      <= 1'b0;
      PARITY_ERR_FLAG  <= 1'b0;
      CRC_ERR_FLAG     <= 1'b0;
      PARITY_LAT_CLKS  <= `SMR_CLK_NONE;
      PARITY_CHECK_ON  <= 1'b0;
      PARITY_ERR_PULSE <= 1'b0;
      CMD_EXEC         <= 1'b0;
      CMD_DROP         <= 1'b0;
      CFG_SUSPECT      <= 1'b0;
    end else begin
      MODE_REG_FIVE <= {cfg_d[`SMR_W-1:`SMR_PAR_ERR+1], par_err_d, crc_err_d,
                        cfg_d[`SMR_LAT_HI:`SMR_LAT_LO]};
      // narrow parts have no shared pin, so both functions stay off
      // readout data leaves uninverted whatever bit 12 says
      RD_INV_EN <= cfg_d[`SMR_RD_INV] & org_wide_q & ~MULTIPURPOSE_READOUT;
      WR_INV_EN <= cfg_d[`SMR_WR_INV] & org_wide_q;
      // masking has no read-side output at all
      WR_MASK_EN      <= cfg_d[`SMR_WR_MASK] & org_wide_q;
      PERSIST_MODE    <= cfg_d[`SMR_PERSIST];
      PARKED_TERM_DIV <= park_div;
      TERM_BUF_ON     <= ~buf_off_pd;
      // parked termination is untouched by the buffer setting
      NOM_TERM_EN      <= term_level & ~buf_off_pd;
      PARITY_ERR_FLAG  <= par_err_d;
      CRC_ERR_FLAG     <= crc_err_d;
      PARITY_LAT_CLKS  <= lat_next;
      PARITY_CHECK_ON  <= check_on_d;
      PARITY_ERR_PULSE <= par_err_set;
      CMD_EXEC         <= exec_valid & exec_ok;
      CMD_DROP         <= exec_valid & ~exec_ok;
      // flags misuse by the controller; the device still obeys the write
      CFG_SUSPECT <= cfg_d[`SMR_RSV_TOP] | cfg_d[`SMR_RSV_A17] | cfg_d[`SMR_RSV_A13] |
                     (cfg_d[`SMR_WR_MASK] & cfg_d[`SMR_WR_INV]) |
                     (load & (exec_data[`SMR_SEL_HI:`SMR_SEL_LO] == `SMR_SEL_NEVER));
    end
  end
endmodule // smr_ctrl
`default_nettype wire

//--- testbench/smr_ctrl_properties.sv
// checker for the fifth mode register block, bound to its top module
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module smr_ctrl_chk (
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire logic        MULTIPURPOSE_READOUT,
  input wire logic        CRC_ERR_DETECT,
  input wire logic [21:0] MODE_REG_FIVE,
  input wire logic        RD_INV_EN,
  input wire logic        PERSIST_MODE,
  input wire logic        TERM_BUF_ON,
  input wire logic        NOM_TERM_EN,
  input wire logic        PARITY_ERR_FLAG,
  input wire logic        CRC_ERR_FLAG,
  input wire logic [3:0]  PARITY_LAT_CLKS,
  input wire logic        PARITY_CHECK_ON,
  input wire logic        PARITY_ERR_PULSE,
  input wire logic        CMD_EXEC,
  input wire logic        CMD_DROP
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  rst_state_a: assert property ($fell(RST) |-> MODE_REG_FIVE == 22'h000000 && TERM_BUF_ON && !CMD_EXEC)
    else $error("state after reset wrong");
  load_cause_a: assert property (!$past(RST) && !$stable(MODE_REG_FIVE[21:5]) |-> CMD_EXEC)
    else $error("configuration moved without a command");
  drop_hold_a: assert property (CMD_DROP |-> $stable(MODE_REG_FIVE[21:5]) && !CMD_EXEC)
    else $error("dropped command changed the register");
  crc_set_a: assert property (CRC_ERR_DETECT |=> CRC_ERR_FLAG)
    else $error("crc flag not set");
  par_flag_a: assert property (PARITY_ERR_PULSE |-> PARITY_ERR_FLAG && MODE_REG_FIVE[4])
    else $error("parity flag not set");
  flag_clear_a: assert property (!$past(RST) && ($fell(PARITY_ERR_FLAG) || $fell(CRC_ERR_FLAG)) |-> CMD_EXEC)
    else $error("flag cleared without a command");
  stop_check_a: assert property (PARITY_ERR_FLAG && !PERSIST_MODE && $stable(PARITY_ERR_FLAG)
    && $stable(PERSIST_MODE) |-> !PARITY_CHECK_ON)
    else $error("checking not suspended");
  buf_nom_a: assert property (!TERM_BUF_ON |-> !NOM_TERM_EN && MODE_REG_FIVE[5])
    else $error("buffer or termination wrong");
  img_flags_a: assert property (MODE_REG_FIVE[4] == PARITY_ERR_FLAG && MODE_REG_FIVE[3] == CRC_ERR_FLAG
    && MODE_REG_FIVE[16:14] == 3'h0)
    else $error("image bits wrong");
  rd_inv_a: assert property (RD_INV_EN |-> MODE_REG_FIVE[12] && !$past(MULTIPURPOSE_READOUT))
    else $error("read inversion wrong");
  lat_map_a: assert property (PARITY_LAT_CLKS == ((MODE_REG_FIVE[2:0] == 3'h4) ? 4'h8 :
    (MODE_REG_FIVE[2:0] == 3'h0 || MODE_REG_FIVE[2:0] > 3'h4) ? 4'h0 : {1'b0, MODE_REG_FIVE[2:0]} + 4'h3))
    else $error("latency decode wrong");
  cover property (CMD_DROP);
  cover property ($rose(CRC_ERR_FLAG));
  cover property (!TERM_BUF_ON);
endmodule // smr_ctrl_chk
bind smr_ctrl smr_ctrl_chk smr_ctrl_chk_inst (.CORE_CLK(CORE_CLK), .RST(RST),
  .MULTIPURPOSE_READOUT(MULTIPURPOSE_READOUT), .CRC_ERR_DETECT(CRC_ERR_DETECT), .MODE_REG_FIVE(MODE_REG_FIVE),
  .RD_INV_EN(RD_INV_EN), .PERSIST_MODE(PERSIST_MODE), .TERM_BUF_ON(TERM_BUF_ON), .NOM_TERM_EN(NOM_TERM_EN),
  .PARITY_ERR_FLAG(PARITY_ERR_FLAG), .CRC_ERR_FLAG(CRC_ERR_FLAG), .PARITY_LAT_CLKS(PARITY_LAT_CLKS),
  .PARITY_CHECK_ON(PARITY_CHECK_ON), .PARITY_ERR_PULSE(PARITY_ERR_PULSE), .CMD_EXEC(CMD_EXEC),
  .CMD_DROP(CMD_DROP));
`default_nettype wire

//--- testbench/smr_ctl_model.sv
// controller model that issues mode-set commands on the command pins
// assumes the bench calls mode_set from one sequence, one command at a time
`timescale 1ns/10ps
`default_nettype none
module smr_ctl_model (
  input  wire logic        clk,
  output var  logic        cke,
  output var  logic        cs_n,
  output var  logic        act_n,
  output var  logic        ras_n,
  output var  logic        cas_n,
  output var  logic        we_n,
  output var  logic [1:0]  bg,
  output var  logic [1:0]  ba,
  output var  logic        a17,
  output var  logic [13:0] addr,
  output var  logic        par
);
  // no gear-down mode here, so latency code 010 is always legal
  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    {act_n, ras_n, cas_n, we_n} = 4'hF;
    {bg, ba, a17, addr, par} = 20'h00000;
  end
  task automatic mode_set(input logic [21:0] v, input logic bad);
    logic [21:0] w;
    w = v & 22'h1DDFFF; // reserved bits always sent as zero
    if (w[11]) w[10] = 1'b0; // masking and write inversion share a pin
    if (w[20:18] != 3'h7) begin // never-use select code is not issued
      @(posedge clk);
      #1;
      cs_n = 1'b0;
      {act_n, ras_n, cas_n, we_n} = 4'h8;
      {bg, ba, a17, addr} = {w[21:17], w[13:0]};
      par = ^{act_n, ras_n, cas_n, we_n, bg, ba, a17, addr} ^ bad;
      @(posedge clk);
      #1;
      cs_n = 1'b1;
      {act_n, ras_n, cas_n, we_n} = 4'hF;
      // deselected lines show the inverse, so a stale copy never passes
      {bg, ba, a17, addr, par} = ~{bg, ba, a17, addr, par};
    end
  endtask
endmodule // smr_ctl_model
`default_nettype wire

//--- testbench/tb_sdram_mode_reg_five_ctrl.sv
// self-checking bench for the fifth mode register block
// assumes the controller model drives every command pin
`timescale 1ns/10ps
`default_nettype none
module tb_sdram_mode_reg_five_ctrl;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        pd = 1'b0;
  logic        mro = 1'b0;
  logic        org = 1'b1;
  logic        crc = 1'b0;
  logic        dtc = 1'b0; // always a valid level
  logic        cke, cs_n, act_n, ras_n, cas_n, we_n, a17, par;
  logic [1:0]  bg, ba;
  logic [13:0] addr;
  logic [21:0] img, last;
  logic        rdi, wri, wmk, pers, tbuf, nom, pflag, cflag, chk_on, ppulse, exec, drop, susp;
  logic [2:0]  div;
  logic [3:0]  lat;
  logic [2:0]  div_tab [8] = '{3'h0, 3'h4, 3'h2, 3'h6, 3'h1, 3'h5, 3'h3, 3'h7};
  logic [3:0]  lat_tab [8] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h8, 4'h0, 4'h0, 4'h0};
  int          n_mismatch = 0;
  int          checks_done = 0;
  always #4 clk = ~clk;
  smr_ctl_model smr_ctl_model_inst (.clk(clk), .cke(cke), .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bg(bg), .ba(ba), .a17(a17), .addr(addr), .par(par));
  smr_ctrl smr_ctrl_inst (.CORE_CLK(clk), .RST(rst), .CKE(cke), .CS_N(cs_n), .ACT_N(act_n), .RAS_N(ras_n),
    .CAS_N(cas_n), .WE_N(we_n), .BG(bg), .BA(ba), .ADDR_A17(a17), .ADDR(addr), .CMD_PARITY_PIN(par),
    .DIE_TERM_CTL(dtc), .POWER_DOWN(pd), .MULTIPURPOSE_READOUT(mro), .ORG_WIDE(org), .CRC_ERR_DETECT(crc),
    .MODE_REG_FIVE(img), .RD_INV_EN(rdi), .WR_INV_EN(wri), .WR_MASK_EN(wmk), .PERSIST_MODE(pers),
    .PARKED_TERM_DIV(div), .TERM_BUF_ON(tbuf), .NOM_TERM_EN(nom), .PARITY_ERR_FLAG(pflag),
    .CRC_ERR_FLAG(cflag), .PARITY_LAT_CLKS(lat), .PARITY_CHECK_ON(chk_on), .PARITY_ERR_PULSE(ppulse),
    .CMD_EXEC(exec), .CMD_DROP(drop), .CFG_SUSPECT(susp));
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // issue one command, then wait bounded for its execute or drop pulse
  task automatic ms(input logic [21:0] v, input logic bad, output int n);
    n = 0;
    smr_ctl_model_inst.mode_set(v, bad);
    while (n < 12 && (bad ? drop : exec) !== 1'b1) begin
      tick(1);
      n++;
    end
    chk(n < 12, "command never completed");
  endtask
  task automatic t_fields();
    int n;
    logic [21:0] v;
    for (int i = 0; i < 8; i++) begin
      v = 22'h140010 | (22'(i) << 6) | (i[0] ? 22'h001000 : 22'h0) | (i[1] ? 22'h000800 : 22'h000400)
        | (i[2] ? 22'h000200 : 22'h0);
      ms(v, 1'b0, n);
      chk(img === (v & 22'h3FFFEF), "image after load");
      chk(div === div_tab[i], "parked divisor");
      chk({rdi, wri, wmk, pers} === {i[0], i[1], ~i[1], i[2]}, "enables");
      chk(susp === 1'b0, "legal write flagged");
    end
    last = img;
    for (int s = 0; s < 7; s++) if (s != 5) begin
      ms({1'b0, 3'(s), 18'h00FFF}, 1'b0, n);
      chk(img === last, "other select changed image");
    end
  endtask
  task automatic t_readout();
    mro = 1'b1;
    tick(2);
    chk(rdi === 1'b0 && wri === 1'b1, "readout inversion");
    mro = 1'b0;
  endtask
  task automatic t_power();
    int n;
    ms(22'h140020, 1'b0, n);
    dtc = 1'b1;
    tick(8);
    chk(nom === 1'b1 && tbuf === 1'b1, "termination awake");
    pd = 1'b1;
    tick(2);
    chk(nom === 1'b0 && tbuf === 1'b0, "buffer off in power-down");
    ms(22'h140000, 1'b0, n);
    tick(1);
    chk(nom === 1'b1 && tbuf === 1'b1, "buffer on in power-down");
    pd = 1'b0;
  endtask
  task automatic t_crc();
    int n;
    crc = 1'b1;
    tick(1);
    crc = 1'b0;
    tick(4);
    chk(cflag === 1'b1 && img[3] === 1'b1, "crc flag set and held");
    ms(22'h100000, 1'b0, n);
    chk(cflag === 1'b1, "crc flag cleared by other select");
    ms(22'h140000, 1'b0, n);
    chk(cflag === 1'b0, "crc flag not cleared");
  endtask
  task automatic t_parity();
    int n;
    chk(img === 22'h000000 && tbuf === 1'b1 && lat === 4'h0 && chk_on === 1'b0, "reset state");
    for (int c = 0; c < 8; c++) begin
      ms(22'h140000 | 22'(c), 1'b0, n);
      chk(lat === lat_tab[c], "latency code");
    end
    ms(22'h140001, 1'b0, n);
    ms(22'h140001, 1'b0, n);
    chk(n >= 5 && n <= 6 && chk_on === 1'b1, "delayed execution");
    ms(22'h140201, 1'b1, n);
    chk(pflag === 1'b1 && img[9] === 1'b0 && chk_on === 1'b0, "bad parity");
    ms(22'h140201, 1'b0, n);
    tick(1);
    chk(pflag === 1'b0 && pers === 1'b1 && chk_on === 1'b1, "persistent load");
    ms(22'h140201, 1'b1, n);
    tick(1);
    chk(pflag === 1'b1 && chk_on === 1'b1, "persistent checking");
    ms(22'h140000, 1'b0, n);
  endtask
  task automatic t_narrow();
    int n;
    org = 1'b0;
    rst = 1'b1;
    tick(3);
    rst = 1'b0;
    ms(22'h141400, 1'b0, n);
    chk(img[12] === 1'b1 && rdi === 1'b0 && wmk === 1'b0, "narrow part gating");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    tick(16);
    rst = 1'b0;
    tick(1);
    t_parity();
    t_fields();
    t_readout();
    t_power();
    t_crc();
    t_narrow();
    report_and_stop();
  end
  initial begin
    #20000;
    n_mismatch++;
    $display("MISMATCH %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule // tb_sdram_mode_reg_five_ctrl
`default_nettype wire
